/* isp_pkg.sv */
package isp_pkg;
    // ==========================================
    // Bus framing and register map
    localparam logic [5:0] ISP_SLV_ADDR_FIXED = 6'h2a;
    localparam logic [6:0] ISP_REG_ADDR_MAX = 7'h7f;
    localparam logic [6:0] ISP_PAGE_SEL_ADDR = 7'h64;
    localparam logic [3:0] ISP_PAGE_SEL_RST = 4'h0;
    localparam int ISP_PAGES = 16;
    localparam int ISP_EVENTS = 8;
    localparam logic [6:0] ISP_ISR_ADDR = 7'h02;
    localparam logic [6:0] ISP_MASK_ADDR = 7'h09;
    localparam logic [6:0] ISP_STATUS_ADDR = 7'h10;
    localparam logic [6:0] ISP_ML_LSB_ADDR = 7'h40;
    localparam logic [6:0] ISP_ML_MID_ADDR = 7'h41;
    localparam logic [6:0] ISP_ML_MSB_ADDR = 7'h42;
    localparam logic [7:0] ISP_MASK_RST = 8'hff;
    // Register access request from link to core domain
    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
    } isp_req_t;
endpackage : isp_pkg

/* isp_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module isp_sync
    import isp_pkg::*;
#(
    parameter int WIDTH = 1
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;
    // ==========================================
    // Two-stage synchroniser; first stage read only by second
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= '0;
            dout <= '0;
        end
        else
        begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : isp_sync
`default_nettype wire

/* isp_link.sv */
`timescale 1ns/100ps
`default_nettype none
module isp_link
    import isp_pkg::*;
(
    input wire logic scl_clk,
    input wire logic rst_link,
    input wire logic sda_in,
    input wire logic addr_sel,
    input wire logic [7:0] rd_data,
    output logic sda_oe,
    output logic req_tgl,
    output isp_req_t req,
    output logic busy
);
    typedef enum {ST_IDLE, ST_SADDR, ST_RADDR, ST_WDATA, ST_RDATA, ST_MACK} isp_lst_t;
    isp_lst_t st_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic [6:0] ptr_q;
    logic ack_q;
    logic ovf_q;
    logic start_q;
    logic start_seen_q;
    // ==========================================
    // Start: sda falling while scl high toggles a flag
    // No stop detector: every frame opens with a start, which restarts the engine
    always_ff @(negedge sda_in or posedge rst_link)
    begin
        if (rst_link)
            start_q <= 1'b0;
        else if (scl_clk)
            start_q <= ~start_q;
    end
    // Reset is asynchronous here because the bus clock stands still between frames
    always_ff @(posedge scl_clk or posedge rst_link)
    begin
        if (rst_link)
            start_seen_q <= 1'b0;
        else
            start_seen_q <= start_q;
    end
    // ==========================================
    // Byte engine on rising scl; data shifted msb first
    // Clocked by the bus itself, so any bit rate up to the fast rate works
    always_ff @(posedge scl_clk or posedge rst_link)
    begin
        if (rst_link)
        begin
            st_q <= ST_IDLE;
            bit_q <= 3'd0;
            sh_q <= 8'h00;
            ptr_q <= 7'h00;
            ack_q <= 1'b0;
            ovf_q <= 1'b0;
            req_tgl <= 1'b0;
            req <= '0;
        end
        else if (start_seen_q != start_q)
        begin
            st_q <= ST_SADDR;
            bit_q <= 3'd1;
            sh_q <= {7'h00, sda_in};
            ack_q <= 1'b0;
        end
        else
        begin
            sh_q <= {sh_q[6:0], sda_in};
            bit_q <= bit_q + 3'd1;
            ack_q <= 1'b0;
            case (st_q)
                ST_SADDR:
                    if (bit_q == 3'd7)
                    begin
                        if (sh_q[6:0] == {ISP_SLV_ADDR_FIXED, addr_sel})
                        begin
                            ack_q <= 1'b1;
                            st_q <= sda_in ? ST_RDATA : ST_RADDR;
                            ovf_q <= 1'b0;
                            if (sda_in)
                            begin
                                req_tgl <= ~req_tgl;
                                req <= '{wr: 1'b0, addr: ptr_q, data: 8'h00};
                            end
                        end
                        else
                            st_q <= ST_IDLE;
                    end
                ST_RADDR:
                    if (bit_q == 3'd7)
                    begin
                        ptr_q <= {sh_q[5:0], sda_in};
                        ack_q <= 1'b1;
                        st_q <= ST_WDATA;
                    end
                ST_WDATA:
                    if (bit_q == 3'd7)
                    begin
                        ack_q <= 1'b1;
                        if (!ovf_q)
                        begin
                            req_tgl <= ~req_tgl;
                            req <= '{wr: 1'b1, addr: ptr_q, data: {sh_q[6:0], sda_in}};
                            if (ptr_q == ISP_REG_ADDR_MAX)
                                ovf_q <= 1'b1;
                            else
                                ptr_q <= ptr_q + 7'd1;
                        end
                    end
                ST_RDATA:
                    if (bit_q == 3'd7)
                        st_q <= ST_MACK;
                ST_MACK:
                begin
                    bit_q <= 3'd0;
                    // Master ack keeps burst going, nack ends it
                    if (!sda_in && !ovf_q)
                    begin
                        st_q <= ST_RDATA;
                        if (ptr_q == ISP_REG_ADDR_MAX)
                            ovf_q <= 1'b1;
                        else
                        begin
                            ptr_q <= ptr_q + 7'd1;
                            req_tgl <= ~req_tgl;
                            req <= '{wr: 1'b0, addr: ptr_q + 7'd1, data: 8'h00};
                        end
                    end
                    else
                        st_q <= ST_IDLE;
                end
                default:
                    st_q <= ST_IDLE;
            endcase
            if (ack_q)
                bit_q <= 3'd0;
        end
    end
    // ==========================================
    // Drive on falling scl: ack low, read data msb first, release otherwise
    // Each returned byte is loaded at its first bit, so a burst picks up the next fetch
    always_ff @(negedge scl_clk or posedge rst_link)
    begin
        if (rst_link)
        begin
            sda_oe <= 1'b0;
            tx_q <= 8'h00;
        end
        else if (ack_q)
            sda_oe <= 1'b1;
        else if (st_q == ST_RDATA && !ovf_q)
        begin
            if (bit_q == 3'd0)
            begin
                tx_q <= rd_data;
                sda_oe <= ~rd_data[7];
            end
            else
                sda_oe <= ~tx_q[3'd7 - bit_q];
        end
        else
            sda_oe <= 1'b0;
    end
    assign busy = (st_q != ST_IDLE);
endmodule : isp_link
`default_nettype wire

/* isp_top.sv */
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Acts only as bus slave answering a 7-bit slave address.
// - Works at 100 kbit/s and 400 kbit/s bit rates.
// - Burst transfers accepted at both bus speeds.
// - Bytes shifted msb first, each followed by an acknowledge bit.
// - Read is an address-setting write, then a read transaction.
// - Slave address is six fixed bits plus the address-select pin.
// - Burst bytes go to successive addresses from the given one.
// - Address stops at 0x7f; further burst bytes ignored.
// - Interrupt output driven low on critical status change.
// - Reference failure, mode change and switchover raise the interrupt.
// - Interrupt status bits stay set after their cause goes away.
// - Reading a sticky register clears its sticky bits.
// - Register space is sixteen pages of locations.
// - Page select at 0x64 maps later addresses to that page.
// - Page select resets to zero.
// - Serial mode pin high selects the two-wire port.
// - Multi-byte values: lsb first, write latched on msb access, read frozen on lsb access.
module isp_top
    import isp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic slave_addr_select_pin,
    input wire logic serial_mode_pin,
    input wire logic [ISP_EVENTS-1:0] event_in,
    input wire logic [7:0] status_in,
    output logic int_n,
    output logic [3:0] page_sel,
    output logic [23:0] ml_value
);
    logic rst_link;
    logic link_oe;
    logic link_tgl;
    isp_req_t link_req;
    logic link_busy;
    logic [7:0] rd_data_q;
    logic tgl_s;
    logic tgl_q;
    logic [ISP_EVENTS-1:0] ev_s;
    logic [ISP_EVENTS-1:0] ev_q;
    logic [ISP_EVENTS-1:0] isr_q;
    logic [ISP_EVENTS-1:0] mask_q;
    logic [7:0] status_s;
    logic mode_s;
    logic asel_s;
    logic [3:0] page_q;
    logic [23:0] ml_q;
    logic [15:0] ml_stage_q;
    logic [23:0] ml_snap_q;
    logic req_go;
    logic rd_isr;
    logic [7:0] rd_mux;
    // ==========================================
    // Link domain reset; held while the four-wire mode is chosen
    // Driven from mclk: the bus clock may stand still, so it cannot time the release
    // Limitation: no frame may begin within a few mclk of enabling the port
    logic lrst_q;
    always_ff @(posedge mclk)
    begin
        lrst_q <= rst | ~mode_s;
    end
    assign rst_link = lrst_q;
    isp_link u_link (
        .scl_clk(scl_clk),
        .rst_link(rst_link),
        .sda_in(sda_in),
        .addr_sel(asel_s),
        .rd_data(rd_data_q),
        .sda_oe(link_oe),
        .req_tgl(link_tgl),
        .req(link_req),
        .busy(link_busy)
    );
    // ==========================================
    // Pin and request-toggle synchronisers into mclk
    isp_sync #(.WIDTH(ISP_EVENTS + 11)) u_sync (
        .clk(mclk),
        .rst(rst),
        .din({event_in, status_in, serial_mode_pin, slave_addr_select_pin, link_tgl}),
        .dout({ev_s, status_s, mode_s, asel_s, tgl_s})
    );
    // Request word is stable for many mclk periods after its toggle
    assign req_go = tgl_s ^ tgl_q;
    assign rd_isr = req_go && !link_req.wr && link_req.addr == ISP_ISR_ADDR && page_q == 4'h0;
    always_ff @(posedge mclk)
    begin
        if (rst)
            tgl_q <= 1'b0;
        else
            tgl_q <= tgl_s;
    end
    // ==========================================
    // Page select
    always_ff @(posedge mclk)
    begin
        if (rst)
            page_q <= ISP_PAGE_SEL_RST;
        else if (req_go && link_req.wr && link_req.addr == ISP_PAGE_SEL_ADDR)
            page_q <= link_req.data[3:0];
    end
    // ==========================================
    // Sticky events, set wins over read clear
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ev_q <= '0;
            isr_q <= '0;
        end
        else
        begin
            ev_q <= ev_s;
            isr_q <= (rd_isr ? '0 : isr_q) | (ev_s & ~ev_q);
        end
    end
    always_ff @(posedge mclk)
    begin
        if (rst)
            mask_q <= ISP_MASK_RST;
        else if (req_go && link_req.wr && link_req.addr == ISP_MASK_ADDR && page_q == 4'h0)
            mask_q <= link_req.data;
    end
    always_ff @(posedge mclk)
    begin
        if (rst)
            int_n <= 1'b1;
        else
            int_n <= ~|(isr_q & mask_q);
    end
    // ==========================================
    // Multi-byte value: write latched on msb, read frozen on lsb
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ml_q <= '0;
            ml_stage_q <= '0;
            ml_snap_q <= '0;
        end
        else if (req_go && page_q == 4'h0)
        begin
            if (link_req.wr)
            begin
                if (link_req.addr == ISP_ML_LSB_ADDR)
                    ml_stage_q[7:0] <= link_req.data;
                if (link_req.addr == ISP_ML_MID_ADDR)
                    ml_stage_q[15:8] <= link_req.data;
                if (link_req.addr == ISP_ML_MSB_ADDR)
                    ml_q <= {link_req.data, ml_stage_q};
            end
            else if (link_req.addr == ISP_ML_LSB_ADDR)
                ml_snap_q <= ml_q;
        end
    end
    // ==========================================
    // Read data; settles well before the link's next falling edge
    always_comb
    begin
        rd_mux = 8'h00;
        if (link_req.addr == ISP_PAGE_SEL_ADDR)
            rd_mux = {4'h0, page_q};
        else if (page_q == 4'h0)
        begin
            case (link_req.addr)
                ISP_ISR_ADDR: rd_mux = isr_q;
                ISP_MASK_ADDR: rd_mux = mask_q;
                ISP_STATUS_ADDR: rd_mux = status_s;
                ISP_ML_LSB_ADDR: rd_mux = ml_q[7:0];
                ISP_ML_MID_ADDR: rd_mux = ml_snap_q[15:8];
                ISP_ML_MSB_ADDR: rd_mux = ml_snap_q[23:16];
                default: rd_mux = 8'h00;
            endcase
        end
    end
    always_ff @(posedge mclk)
    begin
        if (rst)
            rd_data_q <= 8'h00;
        else if (req_go)
            rd_data_q <= rd_mux;
    end
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            page_sel <= ISP_PAGE_SEL_RST;
            ml_value <= '0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end
        else
        begin
            page_sel <= page_q;
            ml_value <= ml_q;
            sda_out <= 1'b0;
            sda_oe <= link_oe;
        end
    end
endmodule : isp_top
`default_nettype wire

/* isp_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module isp_monitor
    import isp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic scl_clk,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic slave_addr_select_pin,
    input wire logic serial_mode_pin,
    input wire logic [ISP_EVENTS-1:0] event_in,
    input wire logic [7:0] status_in,
    input wire logic int_n,
    input wire logic [3:0] page_sel,
    input wire logic [23:0] ml_value
);
    // ==========
    // Idle bus: clock high longer than any bit at either rate
    logic [8:0] hi_q;
    always_ff @(posedge mclk)
    begin
        if (rst || !scl_clk)
            hi_q <= 9'h000;
        else if (hi_q != 9'h1ff)
            hi_q <= hi_q + 9'h001;
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    sequence s_idle;
        hi_q >= 9'h0dc;
    endsequence
    sequence s_mode_off;
        !serial_mode_pin [*8];
    endsequence
    // ==========
    // Checks
    a_reset_vals: assert property (disable iff (1'b0)
        rst |=> page_sel == 4'h0 && int_n && !sda_oe) else $error("bad reset values");
    a_od_low: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    a_idle_release: assert property (s_idle |-> !sda_oe)
        else $error("slave pulls idle bus");
    a_mode_quiet: assert property (s_mode_off |-> !sda_oe)
        else $error("port active in four-wire mode");
    a_idle_regs: assert property (s_idle |=> $stable(page_sel) && $stable(ml_value))
        else $error("register changed on idle bus");
    a_int_sticky: assert property (s_idle ##0 !int_n |=> !int_n)
        else $error("interrupt cleared without a read");
    a_int_cause: assert property ($fell(int_n) |-> event_in != $past(event_in, 6))
        else $error("interrupt without event");
    a_int_release: assert property ($rose(int_n) |-> $past(hi_q) < 9'h0dc)
        else $error("interrupt released on idle bus");
endmodule : isp_monitor

bind isp_top isp_monitor u_mon (
    .mclk(mclk),
    .rst(rst),
    .scl_clk(scl_clk),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .slave_addr_select_pin(slave_addr_select_pin),
    .serial_mode_pin(serial_mode_pin),
    .event_in(event_in),
    .status_in(status_in),
    .int_n(int_n),
    .page_sel(page_sel),
    .ml_value(ml_value)
);
`default_nettype wire

/* isp_host.sv */
`timescale 1ns/100ps
`default_nettype none
module isp_host (
    output logic scl,
    output logic host_oe,
    input wire logic sda
);
    // ==========
    // Bus master; clock stands still between frames
    int hp;
    initial
    begin
        hp = 1250;
        scl = 1'b1;
        host_oe = 1'b0;
    end
    task automatic bit_io(input logic b, output logic r);
        #(hp / 2) host_oe = ~b;
        #(hp / 2) scl = 1'b1;
        #(hp) r = sda;
        scl = 1'b0;
    endtask : bit_io
    task automatic start();
        host_oe = 1'b1;
        #(hp) scl = 1'b0;
    endtask : start
    task automatic stop();
        #(hp / 2) host_oe = 1'b1;
        #(hp / 2) scl = 1'b1;
        #(hp / 2) host_oe = 1'b0;
        #(6500);
    endtask : stop
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wbyte
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(~more, r);
    endtask : rbyte
endmodule : isp_host
`default_nettype wire

/* isp_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import isp_pkg::*;
    logic mclk, rst, scl, host_oe, sda, pin, mode, sda_out, sda_oe, int_n;
    logic [7:0] ev, st;
    logic [3:0] page_sel;
    logic [23:0] ml, v;
    logic [6:0] sa;
    int fail_count, num_checks;
    // Pull-up on the data line
    assign sda = ~(sda_oe | host_oe);
    isp_top DUT (
        .mclk(mclk),
        .rst(rst),
        .scl_clk(scl),
        .sda_in(sda),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .slave_addr_select_pin(pin),
        .serial_mode_pin(mode),
        .event_in(ev),
        .status_in(st),
        .int_n(int_n),
        .page_sel(page_sel),
        .ml_value(ml)
    );
    isp_host HOST (
        .scl(scl),
        .host_oe(host_oe),
        .sda(sda)
    );
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // ==========
    // Tasks
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %s expected %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic pause();
        repeat (20) @(posedge mclk);
        #1;
    endtask : pause
    task automatic wr(input logic [7:0] a, input int n, input logic [23:0] d);
        logic k, ea;
        ea = (sa == {ISP_SLV_ADDR_FIXED, pin}) && mode;
        HOST.start();
        HOST.wbyte({sa, 1'b0}, k);
        chk("addr ack", {23'h0, ea}, {23'h0, k});
        if (k)
        begin
            HOST.wbyte(a, k);
            chk("reg ack", 24'h1, {23'h0, k});
            for (int i = 0; i < n; i++)
            begin
                HOST.wbyte(d[8*i +: 8], k);
                chk("data ack", 24'h1, {23'h0, k});
            end
        end
        HOST.stop();
    endtask : wr
    task automatic rd(input logic [7:0] a, input int n, input logic [23:0] e);
        logic k;
        logic [7:0] b;
        wr(a, 0, 24'h0);
        HOST.start();
        HOST.wbyte({sa, 1'b1}, k);
        chk("rd addr ack", 24'h1, {23'h0, k});
        for (int i = 0; i < n; i++)
        begin
            HOST.rbyte(i < n - 1, b);
            chk("rd data", e[8*i +: 8], {16'h0, b});
        end
        HOST.stop();
    endtask : rd
    task automatic end_of_test();
        if (fail_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    // ==========
    // Tests
    initial
    begin
        rst = 1'b1;
        pin = 1'b0;
        mode = 1'b0;
        ev = 8'h00;
        st = 8'h5a;
        fail_count = 0;
        num_checks = 0;
        repeat (8) @(posedge mclk);
        #1 rst = 1'b0;
        chk("page_sel", 24'h0, {20'h0, page_sel});
        chk("int_n", 24'h1, {23'h0, int_n});
        chk("sda_oe", 24'h0, {23'h0, sda_oe});
        sa = {ISP_SLV_ADDR_FIXED, pin};
        wr(8'h64, 1, 24'h05);
        chk("page_sel", 24'h0, {20'h0, page_sel});
        pause();
        mode = 1'b1;
        pause();
        rd(8'h64, 1, 24'h0);
        wr(8'h64, 1, 24'h0f);
        chk("page_sel", 24'hf, {20'h0, page_sel});
        rd(8'h64, 1, 24'h0f);
        wr(8'h64, 1, 24'h00);
        chk("page_sel", 24'h0, {20'h0, page_sel});
        for (int p = 0; p < 2; p++)
        begin
            pause();
            pin = p[0];
            pause();
            sa = {ISP_SLV_ADDR_FIXED, ~pin};
            wr(8'h64, 1, 24'h03);
            chk("page_sel", 24'h0, {20'h0, page_sel});
            sa = {ISP_SLV_ADDR_FIXED, pin};
            v = {20'h33221, 3'h0, pin};
            wr(8'hc0, 3, v);
            chk("ml_value", v, ml);
            rd(8'h40, 3, v);
        end
        // Slow rate is expensive in run time, so only a burst write runs there
        HOST.hp = 5000;
        v = 24'h665544;
        wr(8'h40, 3, v);
        chk("ml_value", v, ml);
        HOST.hp = 1250;
        wr(8'h40, 2, 24'h7788);
        chk("ml_value", v, ml);
        wr(8'h42, 1, 24'h99);
        chk("ml_value", 24'h997788, ml);
        wr(8'h7f, 3, 24'haabbcc);
        chk("ml_value", 24'h997788, ml);
        chk("page_sel", 24'h0, {20'h0, page_sel});
        rd({1'b0, ISP_MASK_ADDR}, 1, {16'h0, ISP_MASK_RST});
        pause();
        ev = 8'hff;
        pause();
        ev = 8'h00;
        pause();
        chk("int_n", 24'h0, {23'h0, int_n});
        rd({1'b0, ISP_ISR_ADDR}, 1, 24'hff);
        chk("int_n", 24'h1, {23'h0, int_n});
        rd({1'b0, ISP_ISR_ADDR}, 1, 24'h0);
        pause();
        st = 8'ha5;
        pause();
        rd({1'b0, ISP_STATUS_ADDR}, 1, 24'ha5);
        end_of_test();
    end
    // Watchdog: tests take about 2.2 ms; limit kept under 100k mclk cycles
    initial
    begin
        #(2400000);
        fail_count++;
        end_of_test();
    end
endmodule : tb
`default_nettype wire
